/* verification/hall_switch_assertions.sv */
`timescale 1ns/10ps
`include "hall_switch_defs.vh"
module hall_switch_assertions (
  input wire clk,
  input wire nrst,
  input wire signed [`FIELD_W-1:0] field_sample,
  input wire sw_out_q,
  input wire sw_out_oe_q,
  input wire switch_low_q,
  input wire ready_q,
  input wire chop_tick_q,
  input wire [`CHOP_PHASE_W-1:0] chop_phase_q,
  input wire conv_done_q,
  input wire [`FIELD_W-1:0] field_mag_q,
  input wire field_neg_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_end_on; conv_done_q && $past(switch_low_q); endsequence
  sequence s_end_off; conv_done_q && !$past(switch_low_q); endsequence
  chk_pin_drive: assert property (
    sw_out_oe_q == switch_low_q && !sw_out_q) else $error("pin drive");
  chk_operate_at: assert property (
    $rose(switch_low_q) |-> field_mag_q > `OP_THRESH) else $error("operate");
  chk_release_at: assert property (
    $fell(switch_low_q) |-> field_mag_q < `REL_THRESH) else $error("release");
  chk_hyst_on: assert property (
    s_end_on |-> switch_low_q == (field_mag_q >= `REL_THRESH))
    else $error("hold on");
  chk_hyst_off: assert property (
    s_end_off |-> switch_low_q == (field_mag_q > `OP_THRESH))
    else $error("hold off");
  chk_update_instant: assert property (
    $changed(switch_low_q) |-> conv_done_q) else $error("update");
  chk_ready_high: assert property (
    $rose(ready_q) |-> !sw_out_oe_q) else $error("ready");
  chk_done_phase: assert property (
    conv_done_q |-> chop_tick_q && chop_phase_q == 0 && ready_q)
    else $error("done");
  chk_tick_gap: assert property (
    chop_tick_q |-> ##[156:157] chop_tick_q) else $error("tick");
endmodule // hall_switch_assertions

/* verification/omnipolar_hall_switch_logic_tb.sv */
`timescale 1ns/10ps
module omnipolar_hall_switch_logic_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg signed [11:0] fs = 12'h100;
  wire sw_out_q, sw_out_oe_q, switch_low_q, ready_q, pin;
  wire chop_tick_q, conv_done_q, field_neg_q;
  wire [3:0] chop_phase_q;
  wire [11:0] field_mag_q;
  integer fails = 0;
  integer checked = 0;
  initial forever #10 clk = ~clk;
  omnipolar_hall_switch_logic #(.POWER_UP_CYCLES(20)) DUT (
    .clk(clk), .nrst(nrst), .field_sample(fs), .sw_out_q(sw_out_q),
    .sw_out_oe_q(sw_out_oe_q), .switch_low_q(switch_low_q),
    .ready_q(ready_q), .chop_tick_q(chop_tick_q),
    .chop_phase_q(chop_phase_q), .conv_done_q(conv_done_q),
    .field_mag_q(field_mag_q), .field_neg_q(field_neg_q));
  pullup_pin PIN (.drain(sw_out_q), .oe(sw_out_oe_q), .pin(pin));
  task stop_test;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input logic [11:0] e, input logic [11:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error at %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task sf(input logic [11:0] v);
    begin
      @(posedge clk);
      fs <= v;
    end
  endtask
  // Waits for n decisions, or for phase p when n is zero
  task wd(input integer n, input logic [3:0] p);
    integer i;
    begin
      for (i = 0; n > 0 || (n == 0 && chop_phase_q !== p); i = i + 1) begin
        if (i > 9000) begin
          fails = fails + 1;
          stop_test;
        end
        @(posedge clk);
        #1;
        if (conv_done_q === 1'b1 && n > 0)
          n = n - 1;
      end
    end
  endtask
  task t_power;
    integer i;
    begin
      for (i = 0; ready_q !== 1'b1 && i < 500; i = i + 1)
        @(posedge clk) #1;
      if (ready_q !== 1'b1) begin
        fails = fails + 1;
        stop_test;
      end
      chk(12'h001, {11'h0, pin});
      wd(1, 4'h0);
      chk(12'h000, {11'h0, pin});
    end
  endtask
  task t_hyst;
    begin
      sf(12'h080);
      wd(1, 4'h0);
      chk(12'h000, {11'h0, pin});
      sf(12'hff0);
      wd(1, 4'h0);
      chk(12'h001, {11'h0, pin});
      chk(12'h010, field_mag_q);
      sf(12'h0a0);
      wd(1, 4'h0);
      chk(12'h001, {11'h0, pin});
      sf(12'hf00);
      wd(1, 4'h0);
      chk(12'h001, {11'h0, field_neg_q});
      chk(12'h000, {11'h0, pin});
    end
  endtask
  task t_mid;
    begin
      sf(12'h000);
      wd(1, 4'h0);
      wd(0, 4'h8);
      sf(12'h150);
      wd(1, 4'h0);
      chk(12'h0a8, field_mag_q);
      chk(12'h000, {11'h0, pin});
      sf(12'h000);
      wd(1, 4'h0);
      wd(0, 4'h9);
      sf(12'h150);
      wd(1, 4'h0);
      chk(12'h001, {11'h0, pin});
      wd(1, 4'h0);
      chk(12'h000, {11'h0, pin});
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_power;
    t_hyst;
    t_mid;
    stop_test;
  end
endmodule // omnipolar_hall_switch_logic_tb
bind omnipolar_hall_switch_logic hall_switch_assertions chk_i (
  .clk(clk), .nrst(nrst), .field_sample(field_sample),
  .sw_out_q(sw_out_q), .sw_out_oe_q(sw_out_oe_q),
  .switch_low_q(switch_low_q), .ready_q(ready_q),
  .chop_tick_q(chop_tick_q), .chop_phase_q(chop_phase_q),
  .conv_done_q(conv_done_q), .field_mag_q(field_mag_q),
  .field_neg_q(field_neg_q));

/* verification/pullup_pin.sv */
`timescale 1ns/10ps
module pullup_pin (
  input wire drain,
  input wire oe,
  output wire pin
);
  // Released pin floats to the pull-up
  assign pin = oe ? drain : 1'b1;
endmodule // pullup_pin

/* verilog/hall_switch_defs.vh */
// Behaviour
// - Output low when averaged magnitude exceeds operate
// - Output released when magnitude below release
// - Threshold chosen by present output state
// - No field after power-up: output high
// - Output released (high) during power-up interval
// - Output high at end of power-up
// - Strong field: low one conversion after power-up
// - Decision updated only at sampling instants
// - Compare the field averaged over the period
// - Crossing at update: change after one period
// - Crossing before mid-period: half-period latency
// - Crossing after mid-period: waits further period
// - Sixteen chopped measurements complete one conversion
// - Conversion period is sixteen chopping ticks
// - Field bandwidth is chopping rate/16/2
// - Single operating mode, no configuration
// - Nominal conversion period is 50 us
`ifndef HALL_SWITCH_DEFS_VH
`define HALL_SWITCH_DEFS_VH

// Clock
`define CLK_PERIOD_NS 20
`define CLK_RATE_KHZ (1000000 / `CLK_PERIOD_NS)

// Conversion timing
`define CONV_PERIOD_US 50
`define CHOPS_PER_CONV 16
`define CHOP_RATE_KHZ ((`CHOPS_PER_CONV * 1000) / `CONV_PERIOD_US)
`define FIELD_BW_HZ (((`CHOP_RATE_KHZ * 1000) / `CHOPS_PER_CONV) / 2)
`define CHOP_PHASE_W 4
`define CHOP_PHASE_RST 4'h0
`define CHOP_PHASE_LAST 4'hf
`define CHOP_PHASE_STEP 4'h1
`define CHOP_ACC_W 16
`define CHOP_ACC_RST 16'h0000

// Power-up interval, rounded up to whole cycles
`define POWER_UP_NS 62500
`define POWER_UP_CYCLES ((`POWER_UP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_CNT_W 12
`define PWR_CNT_RST 12'h000
`define PWR_CNT_STEP 12'h001

// Field datapath
`define FIELD_W 12
`define AVG_SHIFT 4
`define OP_THRESH 12'h0a0
`define REL_THRESH 12'h060

`endif

/* verilog/omnipolar_hall_switch_logic.v */
`timescale 1ns/10ps
`include "hall_switch_defs.vh"

module omnipolar_hall_switch_logic #(
  parameter W = `FIELD_W,
  parameter [`FIELD_W-1:0] OP_THRESH = `OP_THRESH,
  parameter [`FIELD_W-1:0] REL_THRESH = `REL_THRESH,
  parameter integer POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
  input wire clk,
  input wire nrst,
  input wire signed [W-1:0] field_sample,
  output reg sw_out_q,
  output reg sw_out_oe_q,
  output reg switch_low_q,
  output reg ready_q,
  output reg chop_tick_q,
  output reg [`CHOP_PHASE_W-1:0] chop_phase_q,
  output reg conv_done_q,
  output reg [W-1:0] field_mag_q,
  output reg field_neg_q
);

////////////////////////////////////////////////////////////////////////
// Derived timing
// One mode only; nothing here is programmable

localparam integer CHOP_STEP_I = `CHOP_RATE_KHZ;
localparam integer CHOP_MOD_I = `CLK_RATE_KHZ;
localparam integer PWR_LAST_I = POWER_UP_CYCLES - 1;
localparam [`CHOP_ACC_W-1:0] CHOP_STEP =
  CHOP_STEP_I[`CHOP_ACC_W-1:0];
localparam [`CHOP_ACC_W-1:0] CHOP_MOD =
  CHOP_MOD_I[`CHOP_ACC_W-1:0];
localparam integer FIELD_BW_HZ = `FIELD_BW_HZ;
localparam [`PWR_CNT_W-1:0] PWR_LAST =
  PWR_LAST_I[`PWR_CNT_W-1:0];
localparam SUM_W = W + `AVG_SHIFT;

////////////////////////////////////////////////////////////////////////
// Power-up interval

reg [`PWR_CNT_W-1:0] pwr_cnt_q;
reg [`PWR_CNT_W-1:0] pwr_cnt_d;
reg ready_d;

always @* begin
  pwr_cnt_d = pwr_cnt_q;
  ready_d = ready_q;
  if (!ready_q) begin
    if (pwr_cnt_q == PWR_LAST) begin
      ready_d = 1'b1;
    end else begin
      pwr_cnt_d = pwr_cnt_q + `PWR_CNT_STEP;
    end
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    pwr_cnt_q <= `PWR_CNT_RST;
    ready_q <= 1'b0;
  end else begin
    pwr_cnt_q <= pwr_cnt_d;
    ready_q <= ready_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Chopping tick generator
// Fractional divider: 50 MHz / 320 kHz is not whole

reg [`CHOP_ACC_W-1:0] chop_acc_q;
reg [`CHOP_ACC_W-1:0] chop_acc_d;
reg [`CHOP_ACC_W:0] chop_sum;
reg tick;

always @* begin
  chop_sum = {1'b0, chop_acc_q} + {1'b0, CHOP_STEP};
  tick = 1'b0;
  chop_acc_d = chop_acc_q;
  if (ready_q) begin
    if (chop_sum >= {1'b0, CHOP_MOD}) begin
      tick = 1'b1;
      chop_acc_d = chop_sum[`CHOP_ACC_W-1:0] - CHOP_MOD;
    end else begin
      chop_acc_d = chop_sum[`CHOP_ACC_W-1:0];
    end
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    chop_acc_q <= `CHOP_ACC_RST;
  end else begin
    chop_acc_q <= chop_acc_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Spinning phase: sixteen measurements per conversion

reg [`CHOP_PHASE_W-1:0] chop_phase_d;
reg last_phase;

always @* begin
  last_phase = (chop_phase_q == `CHOP_PHASE_LAST);
  chop_phase_d = chop_phase_q;
  if (tick) begin
    chop_phase_d = chop_phase_q + `CHOP_PHASE_STEP;
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    chop_phase_q <= `CHOP_PHASE_RST;
    chop_tick_q <= 1'b0;
  end else begin
    chop_phase_q <= chop_phase_d;
    chop_tick_q <= tick;
  end
end

////////////////////////////////////////////////////////////////////////
// Field averaging over one conversion

reg signed [SUM_W-1:0] sum_q;
reg signed [SUM_W-1:0] sum_d;
reg signed [SUM_W-1:0] sum_full;
reg signed [SUM_W-1:0] sample_ext;
reg signed [W-1:0] avg;
reg [W-1:0] mag;
reg conv_end;

always @* begin
  sample_ext = {{`AVG_SHIFT{field_sample[W-1]}}, field_sample};
  sum_full = sum_q + sample_ext;
  avg = sum_full[SUM_W-1:`AVG_SHIFT];
  if (avg[W-1]) begin
    mag = -avg;
  end else begin
    mag = avg;
  end
  conv_end = tick && last_phase;
  sum_d = sum_q;
  if (tick) begin
    if (last_phase) begin
      sum_d = {SUM_W{1'b0}};
    end else begin
      sum_d = sum_full;
    end
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    sum_q <= {SUM_W{1'b0}};
  end else begin
    sum_q <= sum_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Hysteresis decision at conversion boundaries

reg switch_low_d;

always @* begin
  switch_low_d = switch_low_q;
  if (!ready_q) begin
    switch_low_d = 1'b0;
  end else if (conv_end) begin
    if (switch_low_q) begin
      if (mag < REL_THRESH) begin
        switch_low_d = 1'b0;
      end
    end else begin
      if (mag > OP_THRESH) begin
        switch_low_d = 1'b1;
      end
    end
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    switch_low_q <= 1'b0;
  end else begin
    switch_low_q <= switch_low_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Open-drain pin drive and status

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    sw_out_q <= 1'b0;
    sw_out_oe_q <= 1'b0;
    conv_done_q <= 1'b0;
    field_mag_q <= {W{1'b0}};
    field_neg_q <= 1'b0;
  end else begin
    sw_out_q <= 1'b0;
    sw_out_oe_q <= switch_low_d;
    conv_done_q <= conv_end;
    if (conv_end) begin
      field_mag_q <= mag;
      field_neg_q <= avg[W-1];
    end
  end
end

endmodule // omnipolar_hall_switch_logic
